//--- rtl/eeprom_slave_pkg.sv
package eeprom_slave_pkg;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [3:0] DEVICE_TYPE = 4'ha;
    localparam int ADDR_WIDTH = 15;
    localparam int PAGE_BITS = 6;
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PROGRAM_TIME_MS = 6;
    localparam longint PROGRAM_CYCLES_L =
        (longint'(PROGRAM_TIME_MS) * 64'd1000000000) / longint'(CLK_PERIOD_PS);
    localparam int PROGRAM_CYCLES = int'(PROGRAM_CYCLES_L);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_WORD_HI = 3'h2,
        ST_WORD_LO = 3'h3,
        ST_WRITE = 3'h4,
        ST_READ = 3'h5,
        ST_WAIT_STOP = 3'h6,
        ST_PROGRAM = 3'h7
    } phase_type;

endpackage

//--- rtl/serial_eeprom_slave.sv
`timescale 1ns/100ps
module serial_eeprom_slave #(
    parameter int PROGRAM_CYCLES = eeprom_slave_pkg::PROGRAM_CYCLES,
    parameter int DEPTH = 1 << eeprom_slave_pkg::ADDR_WIDTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_protect,
    // Status
    output logic program_busy
);

    localparam int AW = eeprom_slave_pkg::ADDR_WIDTH;
    localparam int PB = eeprom_slave_pkg::PAGE_BITS;

    if (DEPTH != (1 << AW) || PROGRAM_CYCLES < 2) begin : g_bad_params
        $error("serial_eeprom_slave: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Input synchronisers and bus events
    // ------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] pin_sync [4];
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [2:0] select_now;
    logic wp_now;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic raw;
            assign raw = (gi == 0) ? select_pin_bit0 : (gi == 1) ? select_pin_bit1 :
                         (gi == 2) ? select_pin_bit2 : write_protect;
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    pin_sync[gi] <= 2'h0;
                end else begin
                    pin_sync[gi] <= {pin_sync[gi][0], raw};
                end
            end
        end
    endgenerate

    assign select_now = {pin_sync[2][1], pin_sync[1][1], pin_sync[0][1]};
    assign wp_now = pin_sync[3][1];
    assign scl_rise = scl_sync[1] && !scl_prev;
    assign scl_fall = !scl_sync[1] && scl_prev;
    assign start_cond = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    assign stop_cond = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [1 << PB];
    logic [(1 << PB)-1:0] page_dirty;

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    eeprom_slave_pkg::phase_type phase, next_phase;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [AW-1:0] addr, next_addr;
    logic in_ack, next_in_ack;
    logic ack_go, next_ack_go;
    logic pending, next_pending;
    logic [31:0] prog_cnt, next_prog_cnt;
    logic next_sda_out, next_sda_oe;
    logic [7:0] rx_byte;

    assign rx_byte = {shift[6:0], sda_sync[1]};

    always_comb begin
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_addr = addr;
        next_in_ack = in_ack;
        next_ack_go = ack_go;
        next_pending = pending;
        next_prog_cnt = prog_cnt;
        next_sda_out = sda_out;
        next_sda_oe = sda_oe;
        if (phase == eeprom_slave_pkg::ST_PROGRAM) begin
            // Bus inputs are ignored entirely while programming.
            next_sda_oe = 1'b0;
            next_prog_cnt = prog_cnt + 32'h1;
            if (prog_cnt >= 32'(PROGRAM_CYCLES - 1)) begin
                next_phase = eeprom_slave_pkg::ST_IDLE;
                next_prog_cnt = 32'h0;
            end
        end else if (stop_cond) begin
            next_sda_oe = 1'b0;
            next_in_ack = 1'b0;
            next_phase = eeprom_slave_pkg::ST_IDLE;
            if (pending) begin
                next_phase = eeprom_slave_pkg::ST_PROGRAM;
                next_prog_cnt = 32'h0;
            end
            next_pending = 1'b0;
        end else if (start_cond) begin
            next_phase = eeprom_slave_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_in_ack = 1'b0;
            next_sda_oe = 1'b0;
        end else if (phase != eeprom_slave_pkg::ST_IDLE) begin
            if (scl_rise && !in_ack) begin
                // A read byte shifts out on the falls, so a rise only counts it.
                if (phase != eeprom_slave_pkg::ST_READ) begin
                    next_shift = rx_byte;
                end
                next_bit_cnt = bit_cnt + 4'h1;
            end
            if (scl_rise && in_ack && phase == eeprom_slave_pkg::ST_READ) begin
                // Master acknowledge is sampled on the ninth clock.
                next_ack_go = !sda_sync[1];
            end
            if (scl_fall && in_ack) begin
                next_in_ack = 1'b0;
                next_bit_cnt = 4'h0;
                next_sda_oe = 1'b0;
                if (phase == eeprom_slave_pkg::ST_READ) begin
                    if (ack_go) begin
                        next_sda_oe = !mem[addr][7];
                        next_sda_out = 1'b0;
                        next_shift = mem[addr];
                        next_addr = addr + 15'h1;
                    end else begin
                        next_phase = eeprom_slave_pkg::ST_WAIT_STOP;
                    end
                end
            end else if (scl_fall && bit_cnt == eeprom_slave_pkg::ACK_SLOT) begin
                next_in_ack = 1'b1;
                next_sda_oe = 1'b0;
                next_sda_out = 1'b0;
                case (phase)
                    eeprom_slave_pkg::ST_ADDR: begin
                        if (shift[7:4] == eeprom_slave_pkg::DEVICE_TYPE
                                && shift[3:1] == select_now) begin
                            next_sda_oe = 1'b1;
                            next_phase = shift[0] ? eeprom_slave_pkg::ST_READ
                                                  : eeprom_slave_pkg::ST_WORD_HI;
                            next_ack_go = 1'b1;
                            next_pending = 1'b0;
                        end else begin
                            next_phase = eeprom_slave_pkg::ST_IDLE;
                        end
                    end
                    eeprom_slave_pkg::ST_WORD_HI: begin
                        next_sda_oe = 1'b1;
                        next_addr = {shift[6:0], addr[7:0]};
                        next_phase = eeprom_slave_pkg::ST_WORD_LO;
                    end
                    eeprom_slave_pkg::ST_WORD_LO: begin
                        next_sda_oe = 1'b1;
                        next_addr = {addr[14:8], shift};
                        next_phase = eeprom_slave_pkg::ST_WRITE;
                    end
                    eeprom_slave_pkg::ST_WRITE: begin
                        if (wp_now) begin
                            next_phase = eeprom_slave_pkg::ST_WAIT_STOP;
                        end else begin
                            next_sda_oe = 1'b1;
                            next_pending = 1'b1;
                            next_addr = {addr[14:6], addr[5:0] + 6'h1};
                        end
                    end
                    eeprom_slave_pkg::ST_READ: begin
                        // The line is released; the master's answer is sampled next rise.
                        next_sda_oe = 1'b0;
                    end
                    default: begin
                        next_in_ack = 1'b0;
                    end
                endcase
            end else if (scl_fall && phase == eeprom_slave_pkg::ST_READ
                    && bit_cnt < eeprom_slave_pkg::ACK_SLOT) begin
                // Each fall puts the next lower bit on the wire.
                next_sda_oe = !shift[6];
                next_shift = {shift[6:0], 1'b0};
            end
        end
    end

    // Read bytes are shifted out MSB first; after loading, bit 7 is on the wire and
    // the counter starts at zero so the eighth fall ends at the ack slot.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase <= eeprom_slave_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            addr <= 15'h0000;
            in_ack <= 1'b0;
            ack_go <= 1'b0;
            pending <= 1'b0;
            prog_cnt <= 32'h0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            program_busy <= 1'b0;
        end else begin
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            addr <= next_addr;
            in_ack <= next_in_ack;
            ack_go <= next_ack_go;
            pending <= next_pending;
            prog_cnt <= next_prog_cnt;
            sda_out <= next_sda_out;
            sda_oe <= next_sda_oe;
            program_busy <= (next_phase == eeprom_slave_pkg::ST_PROGRAM);
        end
    end

    // ------------------------------------------------------------
    // Page buffer and array commit
    // ------------------------------------------------------------
    logic page_load;
    logic commit;
    logic [AW-1:0] page_base;
    logic [AW-1:0] page_base_q;

    assign page_load = phase == eeprom_slave_pkg::ST_WRITE && scl_fall && !in_ack
                       && bit_cnt == eeprom_slave_pkg::ACK_SLOT && !wp_now && !start_cond
                       && !stop_cond;
    assign commit = phase == eeprom_slave_pkg::ST_PROGRAM
                    && prog_cnt >= 32'(PROGRAM_CYCLES - 1);
    assign page_base = {addr[14:6], 6'h00};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            page_dirty <= '0;
            page_base_q <= 15'h0000;
        end else if (commit) begin
            page_dirty <= '0;
        end else if (page_load) begin
            page_dirty[addr[5:0]] <= 1'b1;
            page_base_q <= page_base;
        end
    end

    generate
        for (gi = 0; gi < (1 << PB); gi++) begin : g_page
            always_ff @(posedge sys_clk) begin
                if (page_load && addr[5:0] == 6'(gi)) begin
                    page_buf[gi] <= shift;
                end
            end
        end
    endgenerate

    // One process owns the array; a commit copies every dirty page entry at once.
    always_ff @(posedge sys_clk) begin
        if (commit) begin
            for (int j = 0; j < (1 << PB); j++) begin
                if (page_dirty[j]) begin
                    mem[page_base_q | 15'(j)] <= page_buf[j];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_busy_addr;
        phase == eeprom_slave_pkg::ST_PROGRAM;
    endsequence

    a_busy_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_busy_addr |=> !sda_oe) else $error("bus driven while programming");
    a_program_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
        commit |=> !program_busy) else $error("programming did not end");
    a_stop_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stop_cond && pending && phase != eeprom_slave_pkg::ST_PROGRAM |=> program_busy)
        else $error("stop did not start programming");
    a_wp_no_prog: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wp_now && phase == eeprom_slave_pkg::ST_WRITE |-> !pending)
        else $error("program pending under write protect");
    a_start_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_cond && !stop_cond && phase != eeprom_slave_pkg::ST_PROGRAM
        |=> phase == eeprom_slave_pkg::ST_ADDR && bit_cnt == 4'h0)
        else $error("start did not restart");
    a_nack_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase == eeprom_slave_pkg::ST_WAIT_STOP |-> !sda_oe || in_ack)
        else $error("data driven after master nack");
    a_bad_type: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase == eeprom_slave_pkg::ST_ADDR && scl_fall && !in_ack && !start_cond
        && !stop_cond && bit_cnt == 4'h8 && shift[7:4] != 4'ha |=> !sda_oe)
        else $error("foreign device type acknowledged");
    a_page_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        page_load |=> addr[14:6] == $past(addr[14:6]))
        else $error("write address left its page");

endmodule // serial_eeprom_slave

//--- test/serial_eeprom_two_wire_slave_tb_top.sv
`timescale 1ns/100ps
module serial_eeprom_two_wire_slave_tb_top;
    localparam int PROG = 200;
    localparam int DEPTH = 1 << eeprom_slave_pkg::ADDR_WIDTH;
    logic sys_clk;
    logic rst_n;
    logic [2:0] sel;
    logic write_protect;
    logic sda_out;
    logic sda_oe;
    logic program_busy;
    logic scl;
    logic pull_low;
    logic k;
    logic [7:0] d;
    wire logic sda_line;
    int n_fail;
    int checks;
    int mem [int];
    int ptr;
    logic [31:0] seed;

    // The pull-up holds the line high unless a party drives it.
    assign sda_line = !(pull_low || (sda_oe && !sda_out));

    serial_eeprom_slave #(.PROGRAM_CYCLES(PROG), .DEPTH(DEPTH)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]),
        .write_protect(write_protect), .program_busy(program_busy));

    two_wire_master m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .pull_low(pull_low));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] dev(input logic rd);
        return {eeprom_slave_pkg::DEVICE_TYPE, sel, rd};
    endfunction

    task automatic wrap_up();
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic head(input int a);
        logic [14:0] w;
        w = a[14:0];
        m.start();
        m.wr_byte(dev(1'b0), k);
        chk(k, 1);
        m.wr_byte({1'b0, w[14:8]}, k);
        chk(k, 1);
        m.wr_byte(w[7:0], k);
        chk(k, 1);
    endtask

    // Waits out the program cycle by polling the write address.
    task automatic poll();
        repeat (8) @(negedge sys_clk);
        chk(program_busy, 1);
        for (int i = 0; i < 40; i++) begin
            m.start();
            m.wr_byte(dev(1'b0), k);
            m.stop();
            if (k === 1'b1) begin
                chk(16'(i > 0), 1);
                chk(16'(i <= 2), 1);
                return;
            end
        end
        n_fail++;
        wrap_up();
    endtask

    task automatic write(input int a, input int n);
        int pg;
        pg = a & ~63;
        head(a);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            m.wr_byte(d, k);
            chk(k, 1);
            mem[pg | ((a + i) & 63)] = d;
        end
        m.stop();
        ptr = pg | ((a + n) & 63);
        poll();
    endtask

    task automatic read(input int a, input int n);
        if (a >= 0) begin
            head(a);
            ptr = a;
        end
        m.start();
        m.wr_byte(dev(1'b1), k);
        chk(k, 1);
        for (int i = 0; i < n; i++) begin
            m.rd_byte(d, i < n - 1);
            if (mem.exists(ptr)) chk(d, 16'(mem[ptr]));
            ptr = (ptr + 1) % DEPTH;
        end
        m.q();
        chk(sda_oe, 0);
        m.stop();
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        rst_n = 1'b0;
        sel = 3'h5;
        write_protect = 1'b0;
        seed = 32'h1d;
        n_fail = 0;
        checks = 0;
        ptr = 0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 3; i++) begin
            ptr = int'(rnd() % DEPTH);
            write(ptr, 1);
            read(ptr - 1 < 0 ? 0 : ptr, 1);
        end
        write(128, 2);
        read(128, 1);
        read(-1, 1);
        write(64, 66);
        read(64, 64);
        write(DEPTH - 2, 2);
        write(0, 1);
        read(DEPTH - 2, 3);
        for (int s = 0; s < 9; s++) begin
            d = s < 8 ? {4'ha, 3'(s), 1'b0} : {4'hb, sel, 1'b0};
            m.start();
            m.wr_byte(d, k);
            chk(k, 16'(s == int'(sel)));
            m.stop();
        end
        write_protect = 1'b1;
        head(0);
        m.wr_byte(8'h3c, k);
        chk(k, 0);
        m.stop();
        repeat (8) @(negedge sys_clk);
        chk(program_busy, 0);
        write_protect = 1'b0;
        m.start();
        m.wr_byte(dev(1'b0), k);
        m.wr_byte(8'h00, k);
        m.start();
        m.wr_byte(dev(1'b1), k);
        chk(k, 1);
        m.rd_byte(d, 1'b0);
        chk(d, 16'(mem[0]));
        m.stop();
        wrap_up();
    end
endmodule // serial_eeprom_two_wire_slave_tb_top

//--- test/two_wire_master.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Bus master model: one bit takes 16 sys_clk, 80 ns.
// ------------------------------------------------------------
module two_wire_master (
    // Clock
    input wire logic sys_clk,
    // Bus
    input wire logic sda_line,
    output logic scl,
    output logic pull_low
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end

    task automatic q();
        repeat (4) @(negedge sys_clk);
    endtask

    // Data moves only while SCL is low; edges with SCL high frame a transfer.
    task automatic start();
        q();
        pull_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        pull_low = 1'b1;
        q();
        scl = 1'b0;
    endtask

    task automatic stop();
        q();
        pull_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        pull_low = 1'b0;
        q();
    endtask

    task automatic bit_io(input logic b, output logic s);
        q();
        pull_low = !b;
        q();
        scl = 1'b1;
        q();
        s = sda_line;
        q();
        scl = 1'b0;
    endtask

    // The master releases the line in the ninth bit and reads the answer.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // A missing acknowledge ends a read.
    task automatic rd_byte(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask
endmodule // two_wire_master
